//--- core/acc_alu_core.sv
// Accumulator ALU core with file registers, driven by instruction words over Avalon-MM
// Assumes a master that holds each request until waitrequest is low
// Functional notes
// - Literal add into accumulator, flags C DC Z
// - Accumulator plus file register, flags C DC Z
// - Destination bit: 0 accumulator, 1 file
// - Accumulator AND file, zero flag only
// - Accumulator AND literal, zero flag only
// - Clear one file bit, flags untouched
// - Set one file bit, flags untouched
// - Bit zero: next instruction runs, flags untouched
// - Bit one: next instruction becomes no-operation
// - Clear file register, zero flag set
`timescale 1ns/100ps
`default_nettype none
`include "acc_alu_cfg.svh"

module acc_alu_core
  import acc_alu_pkg::*;
#(
  parameter int FILE_DEPTH = 128,
  parameter int TCY_CLOCKS = `TCY_CLOCKS
)
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Core state
  output logic [7:0] acc_out,
  output logic [2:0] flags_out,
  output logic skip_pending_out
);

  localparam int ADDR_W = $clog2(FILE_DEPTH);

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  state_t state_q;
  state_t state_d;
  logic [7:0] tcy_cnt_q;
  logic [7:0] acc_q;
  logic carry_q;
  logic digit_carry_flag_q;
  logic zero_q;
  logic skip_q;
  logic [ADDR_W-1:0] fptr_q;
  logic [15:0] cycles_q;
  logic [23:0] instr_q;
  logic [31:0] rdata_q;
  logic [7:0] file_q [FILE_DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  wire logic req = avs_read_in | avs_write_in;
  wire logic hit_instr = hit(avs_address_in, `OFF_INSTR);
  wire logic hit_acc = hit(avs_address_in, `OFF_ACC);
  wire logic hit_status = hit(avs_address_in, `OFF_STATUS);
  wire logic hit_fptr = hit(avs_address_in, `OFF_FPTR);
  wire logic hit_fdata = hit(avs_address_in, `OFF_FDATA);
  wire logic hit_cycles = hit(avs_address_in, `OFF_CYCLES);
  wire logic tcy_pulse = (tcy_cnt_q == 8'(TCY_CLOCKS - 1));
  wire logic busy = (state_q == S_RUN);
  wire logic acking = (state_q == S_ACK);
  wire logic commit = acking & avs_write_in & hit_instr;
  wire logic reg_wr = acking & avs_write_in & ~hit_instr & avs_byteenable_in[0];
  wire logic rd_take = (state_q == S_IDLE) & avs_read_in;

  wire op_t instr_op = op_t'(avs_writedata_in[`POS_OP +: 4]);
  wire op_t eff_op = skip_q ? OP_NOP : instr_op;
  wire logic [ADDR_W-1:0] faddr = avs_writedata_in[`POS_FADDR +: ADDR_W];
  wire logic [7:0] status_word = {3'h0, busy, skip_q, zero_q, digit_carry_flag_q, carry_q};

  wire logic [31:0] rd_mux =
    hit_instr ? {8'h00, instr_q} :
    hit_acc ? {24'h00_0000, acc_q} :
    hit_status ? {24'h00_0000, status_word} :
    hit_fptr ? {24'h00_0000, 8'(fptr_q)} :
    hit_fdata ? {24'h00_0000, file_q[fptr_q]} :
    hit_cycles ? {16'h0000, cycles_q} :
    32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic unit

  alu_if bus ();

  assign bus.op = eff_op;
  assign bus.acc = acc_q;
  assign bus.file_val = file_q[faddr];
  assign bus.literal = avs_writedata_in[`POS_LIT +: 8];
  assign bus.bit_sel = avs_writedata_in[`POS_BIT +: 3];
  assign bus.dest = avs_writedata_in[`POS_DEST];

  alu_unit u_alu (
    .bus(bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake

  assign avs_waitrequest_out = req & ~acking;
  assign avs_readdata_out = rdata_q;
  assign acc_out = acc_q;
  assign flags_out = {zero_q, digit_carry_flag_q, carry_q};
  assign skip_pending_out = skip_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_IDLE:
      begin
        if (req)
        begin
          if (avs_write_in & hit_instr)
          begin
            state_d = S_RUN;
          end
          else
          begin
            state_d = S_ACK;
          end
        end
      end
      S_RUN:
      begin
        if (tcy_pulse)
        begin
          state_d = S_ACK;
        end
      end
      S_ACK:
      begin
        state_d = S_IDLE;
      end
      default:
      begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= S_IDLE;
      tcy_cnt_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      tcy_cnt_q <= tcy_pulse ? 8'h00 : tcy_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (rd_take)
    begin
      rdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and flags

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      acc_q <= `RST_ACC;
    end
    else if (commit & bus.to_acc)
    begin
      acc_q <= bus.result;
    end
    else if (reg_wr & hit_acc)
    begin
      acc_q <= avs_writedata_in[7:0];
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      carry_q <= `RST_FLAGS;
      digit_carry_flag_q <= `RST_FLAGS;
      zero_q <= `RST_FLAGS;
    end
    else if (commit)
    begin
      carry_q <= bus.upd_c ? bus.carry : carry_q;
      digit_carry_flag_q <= bus.upd_dc ? bus.digit_carry_flag : digit_carry_flag_q;
      zero_q <= bus.upd_z ? bus.zero : zero_q;
    end
    else if (reg_wr & hit_status)
    begin
      carry_q <= avs_writedata_in[`ST_CARRY];
      digit_carry_flag_q <= avs_writedata_in[`ST_DC];
      zero_q <= avs_writedata_in[`ST_ZERO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Skip, counters and instruction readback

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      skip_q <= 1'b0;
    end
    else if (commit)
    begin
      skip_q <= bus.skip;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      cycles_q <= 16'h0000;
      instr_q <= 24'h00_0000;
    end
    else if (commit)
    begin
      cycles_q <= cycles_q + 16'h0001;
      instr_q <= avs_writedata_in[23:0];
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      fptr_q <= '0;
    end
    else if (reg_wr & hit_fptr)
    begin
      fptr_q <= avs_writedata_in[ADDR_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // File registers

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < FILE_DEPTH; i++)
      begin
        file_q[i] <= `RST_FILE;
      end
    end
    else if (commit & bus.to_file)
    begin
      file_q[faddr] <= bus.result;
    end
    else if (reg_wr & hit_fdata)
    begin
      file_q[fptr_q] <= avs_writedata_in[7:0];
    end
  end

endmodule // acc_alu_core

`default_nettype wire

//--- shared/acc_alu_cfg.svh
// Offsets, field positions, reset values and timing counts of the accumulator ALU block
// Assumes inclusion by bare name from the core
`ifndef ACC_ALU_CFG_SVH
`define ACC_ALU_CFG_SVH

// Register byte offsets
`define OFF_INSTR 8'h00
`define OFF_ACC 8'h04
`define OFF_STATUS 8'h08
`define OFF_FPTR 8'h0C
`define OFF_FDATA 8'h10
`define OFF_CYCLES 8'h14

// Instruction word fields
`define POS_OP 0
`define POS_FADDR 4
`define POS_BIT 11
`define POS_DEST 14
`define POS_LIT 16

// Status bits
`define ST_CARRY 0
`define ST_DC 1
`define ST_ZERO 2
`define ST_SKIP 3
`define ST_BUSY 4

// Reset values
`define RST_ACC 8'h00
`define RST_FLAGS 1'b0
`define RST_FILE 8'h00

// Instruction cycle timing
`define MCLK_NS 10
`define TCY_NS 40
`define TCY_CLOCKS ((`TCY_NS + `MCLK_NS - 1) / `MCLK_NS)

`endif

//--- shared/acc_alu_pkg.sv
// Types shared by the accumulator ALU core and its arithmetic unit
// Assumes the cfg header sits on the include path
package acc_alu_pkg;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_ADD_LITERAL_TO_ACC,
    OP_AND_LITERAL_WITH_ACC,
    OP_ADD_ACC_AND_FILE,
    OP_AND_ACC_WITH_FILE,
    OP_CLEAR_FILE_REGISTER,
    OP_CLEAR_FILE_BIT,
    OP_SET_FILE_BIT,
    OP_TEST_BIT_SKIP_IF_ONE
  } op_t;

  typedef enum {
    S_IDLE,
    S_RUN,
    S_ACK
  } state_t;

endpackage

//--- shared/alu_if.sv
// Operand and result bundle between the core and the arithmetic unit
// Assumes the package is compiled first
`timescale 1ns/100ps
`default_nettype none

interface alu_if;
  import acc_alu_pkg::*;
  op_t op;
  logic [7:0] acc;
  logic [7:0] file_val;
  logic [7:0] literal;
  logic [2:0] bit_sel;
  logic dest;
  logic [7:0] result;
  logic carry;
  logic digit_carry_flag;
  logic zero;
  logic upd_c;
  logic upd_dc;
  logic upd_z;
  logic to_acc;
  logic to_file;
  logic skip;

  modport core (
    output op, acc, file_val, literal, bit_sel, dest,
    input result, carry, digit_carry_flag, zero, upd_c, upd_dc, upd_z, to_acc, to_file, skip
  );
  modport alu (
    input op, acc, file_val, literal, bit_sel, dest,
    output result, carry, digit_carry_flag, zero, upd_c, upd_dc, upd_z, to_acc, to_file, skip
  );
endinterface

`default_nettype wire

//--- core/alu_unit.sv
// Combinational arithmetic, logic and bit unit of the accumulator core
// Assumes operands are stable while the core holds an instruction
`timescale 1ns/100ps
`default_nettype none

module alu_unit
  import acc_alu_pkg::*;
(
  // Operands and results
  alu_if.alu bus
);

  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] opb;
  logic [7:0] mask;

  assign opb = (bus.op == OP_ADD_LITERAL_TO_ACC || bus.op == OP_AND_LITERAL_WITH_ACC) ? bus.literal : bus.file_val;
  assign sum9 = {1'b0, bus.acc} + {1'b0, opb};
  assign nib5 = {1'b0, bus.acc[3:0]} + {1'b0, opb[3:0]};
  assign mask = 8'h01 << bus.bit_sel;
  assign bus.carry = sum9[8];
  assign bus.digit_carry_flag = nib5[4];
  assign bus.zero = (bus.result == 8'h00);

  always_comb
  begin
    bus.result = 8'h00;
    bus.upd_c = 1'b0;
    bus.upd_dc = 1'b0;
    bus.upd_z = 1'b0;
    bus.to_acc = 1'b0;
    bus.to_file = 1'b0;
    bus.skip = 1'b0;
    case (bus.op)
      OP_ADD_LITERAL_TO_ACC:
      begin
        bus.result = sum9[7:0];
        bus.to_acc = 1'b1;
        bus.upd_c = 1'b1;
        bus.upd_dc = 1'b1;
        bus.upd_z = 1'b1;
      end
      OP_AND_LITERAL_WITH_ACC:
      begin
        bus.result = bus.acc & bus.literal;
        bus.to_acc = 1'b1;
        bus.upd_z = 1'b1;
      end
      OP_ADD_ACC_AND_FILE:
      begin
        bus.result = sum9[7:0];
        bus.to_acc = ~bus.dest;
        bus.to_file = bus.dest;
        bus.upd_c = 1'b1;
        bus.upd_dc = 1'b1;
        bus.upd_z = 1'b1;
      end
      OP_AND_ACC_WITH_FILE:
      begin
        bus.result = bus.acc & bus.file_val;
        bus.to_acc = ~bus.dest;
        bus.to_file = bus.dest;
        bus.upd_z = 1'b1;
      end
      OP_CLEAR_FILE_REGISTER:
      begin
        bus.result = 8'h00;
        bus.to_file = 1'b1;
        bus.upd_z = 1'b1;
      end
      OP_CLEAR_FILE_BIT:
      begin
        bus.result = bus.file_val & ~mask;
        bus.to_file = 1'b1;
      end
      OP_SET_FILE_BIT:
      begin
        bus.result = bus.file_val | mask;
        bus.to_file = 1'b1;
      end
      OP_TEST_BIT_SKIP_IF_ONE:
      begin
        bus.skip = bus.file_val[bus.bit_sel];
      end
      default:
      begin
        bus.result = 8'h00;
      end
    endcase
  end

endmodule // alu_unit

`default_nettype wire

//--- test/acc_alu_core_asserts.sv
// Port assertions for the accumulator ALU core
// Assumes a bind onto acc_alu_core
`timescale 1ns/100ps
`default_nettype none
module acc_alu_core_asserts
#(
  parameter int TCY_CLOCKS = 4
)
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Bus
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic avs_waitrequest_out,
  // Core state
  input wire logic [7:0] acc_out,
  input wire logic [2:0] flags_out,
  input wire logic skip_pending_out
);
  localparam int WMAX = TCY_CLOCKS + 2;
  wire done = avs_write_in && !avs_waitrequest_out;
  wire run = done && avs_address_in == 8'h00 && !skip_pending_out;
  wire [3:0] op = avs_writedata_in[3:0];
  wire [7:0] lit = avs_writedata_in[23:16];
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  //////////////////////////////////////////////////////////////////////////////
  property p_reg_ans; avs_read_in && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
  a_reg_ans: assert property (p_reg_ans) else $error("register read not answered");
  property p_ins_ans; $rose(avs_write_in) && avs_address_in == 8'h00 |-> ##[1:WMAX] !avs_waitrequest_out; endproperty
  a_ins_ans: assert property (p_ins_ans) else $error("instruction not answered");
  property p_hold; !done |=> $stable(acc_out) && $stable(flags_out) && $stable(skip_pending_out); endproperty
  a_hold: assert property (p_hold) else $error("state changed without commit");
  property p_add_lit; run && op == 4'h1 |=> acc_out == 8'($past(acc_out) + $past(lit)) && flags_out[2] == (acc_out == 8'h00);
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("literal add wrong");
  property p_and_lit; run && op == 4'h2 |=> acc_out == ($past(acc_out) & $past(lit)) && flags_out[1:0] == $past(flags_out[1:0]);
  endproperty
  a_and_lit: assert property (p_and_lit) else $error("literal and wrong");
  property p_clr; run && op == 4'h5 |=> flags_out == {1'b1, $past(flags_out[1:0])} && $stable(acc_out); endproperty
  a_clr: assert property (p_clr) else $error("clear register flags wrong");
  property p_bits; run && op inside {4'h6, 4'h7, 4'h8} |=> $stable(flags_out) && $stable(acc_out); endproperty
  a_bits: assert property (p_bits) else $error("bit operation touched flags");
  property p_skip; done && avs_address_in == 8'h00 && skip_pending_out |=> !skip_pending_out && $stable(acc_out); endproperty
  a_skip: assert property (p_skip) else $error("skipped instruction not discarded");
  c_skip: cover property (run && op == 4'h8 ##1 skip_pending_out);
  c_file: cover property (run && op == 4'h3 && avs_writedata_in[14]);
  c_nop: cover property (done && avs_address_in == 8'h00 && skip_pending_out);
endmodule // acc_alu_core_asserts
`default_nettype wire

//--- test/accumulator_alu_bit_ops_bench.sv
// Self-checking bench for the accumulator ALU core
// Assumes package, interface, core and checker compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin n_fail++; $display("ERROR %s exp %h got %h", n, e, a); end end
module accumulator_alu_bit_ops_bench;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [7:0] acc_out;
  logic [2:0] flags_out;
  logic skip_pending_out;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int w = 0;
  int n_instr = 0;
  int fm [128];
  bit c, dc, z, sk;
  logic [31:0] q;
  int f;
  acc_alu_core #(.FILE_DEPTH(128), .TCY_CLOCKS(4)) dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .acc_out(acc_out), .flags_out(flags_out), .skip_pending_out(skip_pending_out));
  always #5 mclk_in = ~mclk_in;
  //////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      results();
    end
  end
  // One bus transfer, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wn, input logic [7:0] a, input logic [31:0] d);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wn;
    avs_read_in <= !wn;
    do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic fput(input int a, input int v);
    bus(1'b1, 8'h0c, 32'(a));
    bus(1'b1, 8'h10, 32'(v));
    fm[a] = v;
  endtask
  // Execute one instruction on design and model
  task automatic ex(input int op, input int a, input int b, input int d, input int lit);
    int s;
    int r;
    s = op < 3 ? lit : fm[a];
    r = 0;
    bus(1'b1, 8'h00, 32'(op) | 32'(a) << 4 | 32'(b) << 11 | 32'(d) << 14 | 32'(lit) << 16);
    n_instr++;
    if (sk)
      sk = 0;
    else
    begin
      if (op == 1 || op == 3)
      begin
        r = w + s;
        c = r > 255;
        dc = w % 16 + s % 16 > 15;
      end
      if (op == 2 || op == 4)
        r = w & s;
      if (op == 6)
        fm[a] &= ~(1 << b);
      if (op == 7)
        fm[a] |= 1 << b;
      if (op == 8)
        sk = fm[a] >> b & 1;
      if (op >= 1 && op <= 5)
      begin
        r %= 256;
        z = r == 0;
        if (op < 3 || (op < 5 && d == 0))
          w = r;
        else
          fm[a] = r;
      end
    end
    `CHK("acc", w[7:0], acc_out)
    `CHK("flags", {z, dc, c}, flags_out)
    `CHK("skip", sk, skip_pending_out)
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h3adc_abf3));
    repeat (4) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    bus(1'b0, 8'h08, 32'h0000_0000);
    `CHK("status", 5'h00, q[4:0])
    bus(1'b0, 8'h18, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, q)
    $display("test reset done");
    bus(1'b1, 8'h04, 32'h0000_00ff);
    w = 255;
    ex(1, 0, 0, 0, 1);
    fput(5, 128);
    ex(8, 5, 7, 0, 0);
    ex(1, 0, 0, 0, 7);
    ex(8, 5, 0, 0, 0);
    ex(5, 5, 0, 0, 0);
    ex(0, 5, 0, 0, 0);
    ex(9, 5, 0, 0, 0);
    $display("test boundary done");
    for (int i = 0; i < 8; i++)
      fput(i < 4 ? i : 120 + i, $urandom % 256);
    repeat (200)
    begin
      f = $urandom % 8;
      ex(1 + $urandom % 8, f < 4 ? f : 120 + f, $urandom % 8, $urandom % 2, $urandom % 256);
    end
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, 8'h0c, 32'(i < 4 ? i : 120 + i));
      bus(1'b0, 8'h10, 32'h0000_0000);
      `CHK("file", fm[i < 4 ? i : 120 + i][7:0], q[7:0])
    end
    bus(1'b0, 8'h14, 32'h0000_0000);
    `CHK("cycles", n_instr[15:0], q[15:0])
    bus(1'b0, 8'h08, 32'h0000_0000);
    `CHK("status", {1'b0, sk, z, dc, c}, q[4:0])
    $display("test random done");
    results();
  end
endmodule // accumulator_alu_bit_ops_bench
bind acc_alu_core acc_alu_core_asserts #(.TCY_CLOCKS(TCY_CLOCKS)) chk_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_waitrequest_out(avs_waitrequest_out), .acc_out(acc_out),
  .flags_out(flags_out), .skip_pending_out(skip_pending_out));
`default_nettype wire
